// ---- design/flash_port_defines.vh ----
// Constants for the serial flash port control block
//
// Contract
// - Writing user register top byte locks it forever
// - Lock sets status-2 flag field bits 5:3
// - Factory security register always locked, never programmed
// - Address 8:7 picks register, 6:0 picks byte
// - Byte index all ones is the top byte
// - Four chip-select rises sampling 0,1,0,1 reset
// - Any clock edge aborts the reset sequence
// - Reset in ultra-deep sleep invalidates buffer, volatiles
// - Reset elsewhere keeps buffer, resets volatile bits
// - Non-volatile status copies survive the reset
// - Reset returns interface to single-line mode
// - Non-byte chip-select release discards the operation
// - Wake command runs on release at clock 8 or 40 only
// - Identifier read: 40 clocks, bits 32-40, wake
// - Release at 41/42 gives identifier, stays asleep
// - Status-3 bit 7 picks hold or reset role
// - Quad enable makes pin data line, disables roles
// - Reset role held low refuses every command
// - Hold starts and ends on falling clock
// - Hold tristates output, ignores input and clock
// - Reset deferred until non-volatile operation completes
`ifndef FLASH_PORT_DEFINES_VH
`define FLASH_PORT_DEFINES_VH

// ----------------------------------------------------------------
// Command decode
// ----------------------------------------------------------------
`define CMD_WAKE        8'hAB
`define CMD_BITS        6'h08
`define ID_FIRST_CLK    6'h20
`define ID_LAST_CLK     6'h28
`define CLK_CNT_MAX     6'h3F

// ----------------------------------------------------------------
// Security registers and status fields
// ----------------------------------------------------------------
`define OTP_TOP_BYTE    7'h7F
`define OTP_FACTORY_REG 2'h0
`define SR2_QE_BIT      1
`define SR2_LOCK_LSB    3
`define SR3_ROLE_BIT    7

// ----------------------------------------------------------------
// Reset sequence
// ----------------------------------------------------------------
`define SEQ_LAST_STAGE  2'h3
`define PIN_IDLE        4'hA  // Idle pin levels: io3 high, si low, cs_n high, sck low

`endif

// ---- design/sync_two_stage.v ----
// Two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps
`default_nettype none

module sync_two_stage #(
   parameter             WIDTH   = 1,
   parameter [WIDTH-1:0] RST_VAL = {WIDTH{1'b0}}  // Idle level of each pin
) (
   input  wire             mclk,    // System clock
   input  wire             arst_n,  // Async reset, active low
   input  wire [WIDTH-1:0] d,       // Asynchronous inputs
   output reg  [WIDTH-1:0] q        // Synchronised outputs
);

   reg [WIDTH-1:0] meta;

   // First stage feeds only the second
   always @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         meta <= RST_VAL;
         q    <= RST_VAL;
      end else begin
         meta <= d;
         q    <= meta;
      end
   end

endmodule
`default_nettype wire

// ---- design/reset_seq_detect.v ----
// Detector for the four-pulse chip-select reset sequence
`timescale 1ns/1ps
`default_nettype none
`include "flash_port_defines.vh"

module reset_seq_detect (
   input  wire mclk,      // System clock
   input  wire arst_n,    // Async reset, active low
   input  wire cs_rise,   // Chip select deasserted, one cycle
   input  wire sck_edge,  // Any serial clock edge, one cycle
   input  wire si_level,  // Synchronised serial input
   output reg  seq_hit    // Sequence complete, one cycle
);

   reg [1:0] stage;       // Pulses matched so far
   reg       clk_seen;    // Clock edge since last chip-select rise

   // Stage advances on matching, clockless pulses
   always @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         stage    <= 2'h0;
         clk_seen <= 1'b0;
         seq_hit  <= 1'b0;
      end else begin
         seq_hit <= 1'b0;
         if (sck_edge) begin
            stage    <= 2'h0;
            clk_seen <= 1'b1;
         end else if (cs_rise) begin
            clk_seen <= 1'b0;
            if (clk_seen) begin
               stage <= 2'h0;
            end else if (si_level == stage[0]) begin
               if (stage == `SEQ_LAST_STAGE) begin
                  stage   <= 2'h0;
                  seq_hit <= 1'b1;
               end else begin
                  stage <= stage + 2'h1;
               end
            end else begin
               stage <= si_level ? 2'h0 : 2'h1;
            end
         end
      end
   end

endmodule
`default_nettype wire

// ---- design/flash_port_ctrl.v ----
// Serial flash port control: reset sequence, hold/reset pin, wake, OTP lock
`timescale 1ns/1ps
`default_nettype none
`include "flash_port_defines.vh"

module flash_port_ctrl #(
   parameter [7:0] DEVICE_ID = 8'h5A  // Arbitrary identifier value
) (
   input  wire       mclk,                  // System clock, 10 MHz
   input  wire       arst_n,                // Async reset, active low
   input  wire       sck,                   // Serial clock pin
   input  wire       cs_n,                  // Chip select pin, active low
   input  wire       si,                    // Serial input pin
   output reg        so,                    // Serial output pin value
   output reg        so_oe,                 // Serial output enable
   input  wire       io3_in,                // Shared hold/reset/io3 pin in
   output reg        io3_out,               // Shared pin drive value
   output reg        io3_oe,                // Shared pin drive enable
   input  wire [7:0] status3_cfg,           // Status register 3 image
   input  wire       quad_lane_enable,      // Quad enable bit
   input  wire       ultra_deep_sleep_mode, // Device in ultra-deep sleep
   input  wire       enter_deep_sleep,      // Enter deep sleep, pulse
   input  wire       nv_busy,               // Non-volatile write in progress
   input  wire       quad_active,           // Multi-line mode active
   input  wire [2:0] lock_init,             // Stored lock flags, loaded once
   input  wire       otp_req,               // Security program request pulse
   input  wire [8:0] otp_addr,              // Security program address
   output reg        otp_grant,             // Program accepted, pulse
   output reg        otp_refuse,            // Program refused, pulse
   output reg  [2:0] security_lock_flags,   // Lock flags of user registers
   output reg  [7:0] status2_lock_view,     // Status 2 lock/quad bits
   output reg        deep_sleep_mode,       // Device in deep sleep
   output reg        cmd_done,              // Command byte-aligned end, pulse
   output reg  [7:0] cmd_code,              // Last command byte
   output reg        op_discard,            // Non-byte release, pulse
   output reg        hold_active,           // Hold in effect
   output reg        dev_in_reset,          // Held by reset pin
   output reg        seq_reset,             // Chip-select reset applied, pulse
   output reg        buffer_invalid,        // Buffer undefined, pulse
   output reg        volatile_clear,        // Volatile status to defaults, pulse
   output reg        single_line_mode       // Single-line transfers restored
);

   // ----------------------------------------------------------------
   // Pin synchronisation and edges
   // ----------------------------------------------------------------
   wire [3:0] pin_sync;
   reg  [3:0] pin_last;
   wire       sck_s  = pin_sync[0];
   wire       cs_s   = pin_sync[1];
   wire       si_s   = pin_sync[2];
   wire       io3_s  = pin_sync[3];

   sync_two_stage #(
      .WIDTH   (4),
      .RST_VAL (`PIN_IDLE)
   ) u_sync (
      .mclk   (mclk),
      .arst_n (arst_n),
      .d      ({io3_in, si, cs_n, sck}),
      .q      (pin_sync)
   );

   // Previous synchronised values for edge finding
   always @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         pin_last <= `PIN_IDLE;
      end else begin
         pin_last <= pin_sync;
      end
   end

   wire sck_rise_raw = sck_s & ~pin_last[0];
   wire sck_fall_raw = ~sck_s & pin_last[0];
   wire cs_rise      = cs_s & ~pin_last[1];
   wire pin_role_on  = ~quad_lane_enable;
   wire role_reset   = status3_cfg[`SR3_ROLE_BIT];
   wire hold_pin_low = pin_role_on & ~role_reset & ~io3_s;
   wire rst_pin_low  = pin_role_on & role_reset & ~io3_s;

   // Clock edges reach the shifter only outside hold and pin reset
   wire sck_rise = sck_rise_raw & ~hold_active & ~dev_in_reset;
   wire sck_fall = sck_fall_raw & ~hold_active & ~dev_in_reset;

   // ----------------------------------------------------------------
   // Helper
   // ----------------------------------------------------------------
   function on_boundary;
      input [5:0] n;
      begin
         on_boundary = (n[2:0] == 3'h0);
      end
   endfunction

   // ----------------------------------------------------------------
   // Reset pin and hold
   // ----------------------------------------------------------------
   // Reset role: level follows pin, no command accepted while low
   always @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         dev_in_reset <= 1'b0;
      end else begin
         dev_in_reset <= rst_pin_low;
      end
   end

   // Hold changes only on falling clock, dropped while chip select is high or the pin role is not hold
   always @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         hold_active <= 1'b0;
      end else if (cs_s || !pin_role_on || role_reset) begin
         hold_active <= 1'b0;
      end else if (sck_fall_raw) begin
         hold_active <= hold_pin_low;
      end
   end

   // Shared pin is not driven by this block
   always @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         io3_out <= 1'b0;
         io3_oe  <= 1'b0;
      end else begin
         io3_out <= 1'b0;
         io3_oe  <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // Clock counter and command capture
   // ----------------------------------------------------------------
   reg  [5:0] clk_cnt;
   reg  [7:0] shift_in;
   wire [5:0] next_clk_cnt = (clk_cnt == `CLK_CNT_MAX) ? clk_cnt : clk_cnt + 6'h01;

   // Count rising clocks inside a frame, sample input on the first eight
   always @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         clk_cnt  <= 6'h00;
         shift_in <= 8'h00;
      end else if (cs_s || dev_in_reset) begin
         clk_cnt  <= 6'h00;
      end else if (sck_rise) begin
         clk_cnt <= next_clk_cnt;
         if (clk_cnt < `CMD_BITS) begin
            shift_in <= {shift_in[6:0], si_s};
         end
      end
   end

   wire is_wake = (shift_in == `CMD_WAKE);

   // End of frame: execute on byte boundary, discard otherwise
   always @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         cmd_done   <= 1'b0;
         cmd_code   <= 8'h00;
         op_discard <= 1'b0;
      end else begin
         cmd_done   <= 1'b0;
         op_discard <= 1'b0;
         if (cs_rise && !dev_in_reset && clk_cnt != 6'h00) begin
            if (!on_boundary(clk_cnt)) begin
               op_discard <= 1'b1;
            end else if (clk_cnt >= `CMD_BITS) begin
               cmd_done <= 1'b1;
               cmd_code <= shift_in;
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // Identifier output
   // ----------------------------------------------------------------
   wire id_window = is_wake && (clk_cnt >= `ID_FIRST_CLK) && (clk_cnt < `ID_LAST_CLK);

   // Drive identifier bits on falling clock, tristate in hold
   always @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         so    <= 1'b0;
         so_oe <= 1'b0;
      end else begin
         if (sck_fall && id_window) begin
            so <= DEVICE_ID[~clk_cnt[2:0]];
         end
         so_oe <= id_window && !cs_s && !(sck_fall_raw ? hold_pin_low : hold_active);
      end
   end

   // ----------------------------------------------------------------
   // Chip-select reset sequence
   // ----------------------------------------------------------------
   wire seq_hit;
   reg  seq_pending;

   reset_seq_detect u_seq (
      .mclk     (mclk),
      .arst_n   (arst_n),
      .cs_rise  (cs_rise),
      .sck_edge (sck_rise_raw | sck_fall_raw),
      .si_level (si_s),
      .seq_hit  (seq_hit)
   );

   wire seq_apply = (seq_hit | seq_pending) & ~nv_busy;

   // Hold a detected reset until the non-volatile operation ends
   always @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         seq_pending <= 1'b0;
      end else if (seq_apply) begin
         seq_pending <= 1'b0;
      end else if (seq_hit) begin
         seq_pending <= 1'b1;
      end
   end

   // Reset effects; non-volatile status copies are not touched here
   always @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         seq_reset        <= 1'b0;
         buffer_invalid   <= 1'b0;
         volatile_clear   <= 1'b0;
         single_line_mode <= 1'b1;
      end else begin
         seq_reset      <= seq_apply;
         buffer_invalid <= seq_apply & ultra_deep_sleep_mode;
         volatile_clear <= seq_apply;
         if (seq_apply) begin
            single_line_mode <= 1'b1;
         end else begin
            single_line_mode <= ~quad_active;
         end
      end
   end

   // ----------------------------------------------------------------
   // Deep sleep
   // ----------------------------------------------------------------
   wire wake_exec = cs_rise && !dev_in_reset && is_wake &&
                    (clk_cnt == `CMD_BITS || clk_cnt == `ID_LAST_CLK);

   // Wake on the exact command or identifier length, or on a sequence reset
   always @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         deep_sleep_mode <= 1'b0;
      end else if (wake_exec || seq_apply) begin
         deep_sleep_mode <= 1'b0;
      end else if (enter_deep_sleep) begin
         deep_sleep_mode <= 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // Security register program and lock
   // ----------------------------------------------------------------
   reg        lock_loaded;
   wire [1:0] otp_sel    = otp_addr[8:7];
   wire [6:0] otp_byte   = otp_addr[6:0];
   wire       sel_factory = (otp_sel == `OTP_FACTORY_REG);
   wire       sel_locked  = sel_factory | security_lock_flags[otp_sel - 2'h1];

   // Load stored flags after reset, then lock on top-byte programming
   always @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         lock_loaded         <= 1'b0;
         security_lock_flags <= 3'h0;
         otp_grant           <= 1'b0;
         otp_refuse          <= 1'b0;
      end else begin
         otp_grant  <= 1'b0;
         otp_refuse <= 1'b0;
         if (!lock_loaded) begin
            lock_loaded         <= 1'b1;
            security_lock_flags <= lock_init;
         end else if (otp_req) begin
            if (sel_locked) begin
               otp_refuse <= 1'b1;
            end else begin
               otp_grant <= 1'b1;
               if (otp_byte == `OTP_TOP_BYTE) begin
                  security_lock_flags[otp_sel - 2'h1] <= 1'b1;
               end
            end
         end
      end
   end

   // Status register 2 view with lock field and quad bit
   always @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         status2_lock_view <= 8'h00;
      end else begin
         status2_lock_view <= 8'h00;
         status2_lock_view[`SR2_LOCK_LSB +: 3] <= security_lock_flags;
         status2_lock_view[`SR2_QE_BIT]        <= quad_lane_enable;
      end
   end

endmodule
`default_nettype wire

// ---- dv/flash_port_monitor.sv ----
// Concurrent checks on the ports of the serial flash port control block
`timescale 1ns/1ps
`default_nettype none

module flash_port_monitor (
   input wire logic       mclk,                  // Clock
   input wire logic       arst_n,                // Reset, active low
   input wire logic       so_oe,                 // Output enable
   input wire logic       quad_lane_enable,      // Quad bit
   input wire logic       ultra_deep_sleep_mode, // Deepest sleep
   input wire logic       nv_busy,               // Non-volatile busy
   input wire logic       otp_req,               // Program request
   input wire logic [8:0] otp_addr,              // Program address
   input wire logic       otp_grant,             // Program taken
   input wire logic       otp_refuse,            // Program refused
   input wire logic [2:0] security_lock_flags,   // Lock flags
   input wire logic [7:0] status2_lock_view,     // Status 2 view
   input wire logic       deep_sleep_mode,       // Asleep
   input wire logic       cmd_done,              // Byte-aligned end
   input wire logic       op_discard,            // Off-boundary end
   input wire logic       hold_active,           // Hold on
   input wire logic       dev_in_reset,          // Reset pin held
   input wire logic       seq_reset,             // Sequence reset
   input wire logic       buffer_invalid,        // Buffer lost
   input wire logic       volatile_clear,        // Volatiles cleared
   input wire logic       single_line_mode       // Single line
);
   // -----------------------------------------------------------
   // Properties
   // -----------------------------------------------------------
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!arst_n);

   // Program of an unlocked user register top byte
   sequence s_top_req;
      otp_req && otp_addr[8:7] != 2'h0 && otp_addr[6:0] == 7'h7F
         && !security_lock_flags[otp_addr[8:7] - 2'h1];
   endsequence
   // Program of a locked user register
   sequence s_locked_req;
      otp_req && otp_addr[8:7] != 2'h0 && security_lock_flags[otp_addr[8:7] - 2'h1];
   endsequence

   a_factory_refused: assert property (
      otp_req && otp_addr[8:7] == 2'h0 |=> otp_refuse && !otp_grant)
      else $error("factory register program not refused");
   a_top_byte_locks: assert property (
      s_top_req |=> otp_grant && security_lock_flags[$past(otp_addr[8:7]) - 2'h1])
      else $error("top byte program did not lock");
   a_locked_refused: assert property (
      s_locked_req |=> otp_refuse && !otp_grant)
      else $error("locked register program not refused");
   a_lock_view_follows: assert property (
      status2_lock_view[5:3] == $past(security_lock_flags))
      else $error("status 2 lock field wrong");
   a_lock_never_clears: assert property (
      ($past(security_lock_flags) & ~security_lock_flags) == 3'h0)
      else $error("lock flag cleared");
   a_seq_side_effects: assert property (
      seq_reset |-> volatile_clear && single_line_mode
         && buffer_invalid == $past(ultra_deep_sleep_mode))
      else $error("sequence reset effects wrong");
   a_seq_deferred: assert property (
      $past(nv_busy) |-> !seq_reset)
      else $error("sequence reset during busy");
   a_hold_quiet: assert property (
      hold_active |-> !so_oe)
      else $error("output driven in hold");
   a_reset_pin_blocks: assert property (
      $past(dev_in_reset) |-> !cmd_done && !op_discard)
      else $error("command ended while in reset");
   a_quad_no_roles: assert property (
      quad_lane_enable [*3] |-> !hold_active && !dev_in_reset)
      else $error("pin role active in quad mode");
   a_done_excl: assert property (
      !(cmd_done && op_discard))
      else $error("done and discard together");
   a_sleep_exit_cause: assert property (
      $fell(deep_sleep_mode) |-> cmd_done || seq_reset)
      else $error("sleep left without command");
endmodule

bind flash_port_ctrl flash_port_monitor u_mon (.*);
`default_nettype wire

// ---- dv/spi_host_model.sv ----
// Host model driving the serial bus and the shared pin of the flash port
`timescale 1ns/1ps
`default_nettype none

module spi_host_model (
   input  wire logic        mclk,   // System clock
   input  wire logic        so,     // Data from the device
   output var  logic        sck,    // Serial clock, mode 0
   output var  logic        cs_n,   // Chip select, active low
   output var  logic        si,     // Data to the device
   output var  logic        pin3_n, // Shared hold/reset pin
   output var  logic [47:0] rx      // Bits taken in clock high phase
);
   // -----------------------------------------------------------
   // Bus tasks, clock period 8 mclk
   // -----------------------------------------------------------
   initial begin
      sck    = 1'b0;
      cs_n   = 1'b1;
      si     = 1'b0;
      pin3_n = 1'b1;
      rx     = 48'h0000_0000_0000;
   end

   task automatic tick(input int n);
      repeat (n) @(posedge mclk);
   endtask

   // Frame of n clocks, MSB first; hold is applied after clock hold_at
   task automatic frame(input logic [47:0] d, input int n, input int hold_at);
      int i;
      cs_n <= 1'b0;
      for (i = 0; i < n; i++) begin
         si  <= d[47 - i];
         sck <= 1'b0;
         if (i > 0)
            rx <= {rx[46:0], so};
         tick(4);
         sck <= 1'b1;
         tick(4);
         if (i == hold_at) begin
            pin3_n <= 1'b0; // chip select stays low throughout
            repeat (3) begin
               tick(4);
               sck <= ~sck;
            end
            tick(4);
            pin3_n <= 1'b1;
            sck    <= 1'b1;
            tick(4);
         end
      end
      sck <= 1'b0;
      rx  <= {rx[46:0], so};
      tick(4);
      cs_n <= 1'b1;
      si   <= ~si; // Released line shows no stale level
      tick(8);
   endtask

   // Chip-select pulses, level set with each fall; clock toggles at abort_at
   task automatic cs_pulses(input logic [7:0] p, input int n, input int abort_at);
      int i;
      for (i = 0; i < n; i++) begin
         cs_n <= 1'b0;
         si   <= p[7 - i];
         tick(4);
         if (i == abort_at) begin
            sck <= 1'b1;
            tick(4);
            sck <= 1'b0;
            tick(4);
         end
         cs_n <= 1'b1; // clock held idle
         tick(4);
      end
      tick(8);
   endtask

   task automatic set_pin(input logic v);
      pin3_n <= v;
   endtask
endmodule
`default_nettype wire

// ---- dv/tb.sv ----
// Testbench of the serial flash port control block
`timescale 1ns/1ps
`default_nettype none

module tb;
   localparam logic [7:0]  ID_VALUE = 8'hC3; // Arbitrary identifier value
   localparam logic [47:0] WAKE_CMD = 48'hAB00_0000_0000;
   logic             mclk, arst_n = 1'b0, otp_req = 1'b0, enter_deep_sleep = 1'b0;
   logic             nv_busy = 1'b0, quad_active = 1'b0, quad_lane_enable = 1'b0;
   logic             ultra_deep_sleep_mode = 1'b0;
   logic [7:0]       status3_cfg = 8'h00;
   logic [8:0]       otp_addr = 9'h000;
   logic [2:0]       lock_init = 3'h0;
   logic [4:0]       seen = 5'h00; // Sticky: done, discard, seq reset, buffer lost, hold
   wire logic        sck, cs_n, si, pin3_n, so, so_oe, otp_grant, otp_refuse, so_line;
   wire logic        deep_sleep_mode, cmd_done, op_discard, hold_active, dev_in_reset;
   wire logic        seq_reset, buffer_invalid, volatile_clear, single_line_mode;
   wire logic [2:0]  security_lock_flags;
   wire logic [7:0]  status2_lock_view, cmd_code;
   wire logic [47:0] rx;
   int               n_mismatch = 0;
   int               n_compared = 0;

   // -----------------------------------------------------------
   // Device, host and clock
   // -----------------------------------------------------------
   flash_port_ctrl #(.DEVICE_ID(ID_VALUE)) uut (.mclk, .arst_n, .sck, .cs_n, .si, .so,
      .so_oe, .io3_in(pin3_n), .io3_out(), .io3_oe(), .status3_cfg, .quad_lane_enable,
      .ultra_deep_sleep_mode, .enter_deep_sleep, .nv_busy, .quad_active, .lock_init,
      .otp_req, .otp_addr, .otp_grant, .otp_refuse, .security_lock_flags, .status2_lock_view,
      .deep_sleep_mode, .cmd_done, .cmd_code, .op_discard, .hold_active, .dev_in_reset,
      .seq_reset, .buffer_invalid, .volatile_clear, .single_line_mode);
   assign so_line = so_oe ? so : ~so; // Undriven output never shows a stale bit
   spi_host_model host (.mclk, .so(so_line), .sck, .cs_n, .si, .pin3_n, .rx);
   initial begin
      mclk = 1'b0;
      forever #50 mclk = ~mclk;
   end
   always @(posedge mclk)
      seen <= seen | {cmd_done, op_discard, seq_reset, buffer_invalid, hold_active};

   // -----------------------------------------------------------
   // Helpers
   // -----------------------------------------------------------
   task automatic check(input string what, input logic [7:0] got, input logic [7:0] exp);
      n_compared++;
      if (got !== exp) begin
         n_mismatch++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic clr();
      @(negedge mclk);
      seen = 5'h00;
   endtask
   task automatic sleep();
      @(posedge mclk);
      enter_deep_sleep <= 1'b1;
      @(posedge mclk);
      enter_deep_sleep <= 1'b0;
      clr();
   endtask
   task automatic otp(input logic [8:0] a, input logic grant);
      @(posedge mclk);
      otp_req  <= 1'b1;
      otp_addr <= a;
      @(posedge mclk);
      otp_req <= 1'b0;
      #1;
      check("grant", 8'({otp_grant, otp_refuse}), 8'({grant, ~grant}));
   endtask
   task automatic end_of_test();
      $display("compared %0d mismatches %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   // -----------------------------------------------------------
   // Scenarios
   // -----------------------------------------------------------
   task automatic t_otp();
      otp(9'h07F, 1'b0);
      otp(9'h105, 1'b1);
      check("locks", 8'(security_lock_flags), 8'h00);
      otp(9'h17F, 1'b1);
      check("locks", 8'(security_lock_flags), 8'h02);
      @(posedge mclk);
      #1;
      check("view", status2_lock_view, 8'h10);
      otp(9'h105, 1'b0);
      otp(9'h0FF, 1'b1);
      otp(9'h1FF, 1'b1);
      check("locks", 8'(security_lock_flags), 8'h07);
      $display("test otp done");
   endtask
   task automatic t_wake();
      int n;
      for (n = 8; n <= 42; n += (n == 10) ? 30 : 1) begin
         sleep();
         host.frame(WAKE_CMD, n, -1);
         check("asleep", 8'(deep_sleep_mode), 8'(n != 8 && n != 40));
         check("end kind", 8'(seen[4:3]), (n % 8 == 0) ? 8'h02 : 8'h01);
         if (n >= 40)
            check("ident", rx[n - 33 -: 8], ID_VALUE);
      end
      check("code", cmd_code, 8'hAB);
      $display("test wake done");
   endtask
   task automatic t_hold();
      sleep();
      host.frame(WAKE_CMD, 8, 3);
      check("hold seen", 8'(seen[0]), 8'h01);
      check("asleep", 8'(deep_sleep_mode), 8'h00);
      check("hold end", 8'(hold_active), 8'h00);
      $display("test hold done");
   endtask
   task automatic t_pin_reset();
      @(posedge mclk);
      status3_cfg <= 8'h80;
      host.set_pin(1'b0);
      repeat (6) @(posedge mclk);
      check("in reset", 8'(dev_in_reset), 8'h01);
      sleep();
      host.frame(WAKE_CMD, 8, -1);
      check("refused", 8'({deep_sleep_mode, seen[4]}), 8'h02);
      quad_lane_enable <= 1'b1;
      repeat (6) @(posedge mclk);
      check("quad", 8'(dev_in_reset), 8'h00);
      host.set_pin(1'b1);
      quad_lane_enable <= 1'b0;
      status3_cfg      <= 8'h00;
      $display("test reset pin done");
   endtask
   task automatic t_seq();
      @(posedge mclk);
      ultra_deep_sleep_mode <= 1'b1;
      quad_active           <= 1'b1;
      clr();
      host.cs_pulses(8'h50, 4, -1);
      check("seq deep", 8'(seen[2:1]), 8'h03);
      ultra_deep_sleep_mode <= 1'b0;
      clr();
      host.cs_pulses(8'h28, 5, -1);
      check("seq restart", 8'(seen[2:1]), 8'h02);
      clr();
      host.cs_pulses(8'h50, 4, 2);
      check("seq abort", 8'(seen[2]), 8'h00);
      nv_busy <= 1'b1;
      clr();
      host.cs_pulses(8'h50, 4, -1);
      repeat (2) @(posedge mclk);
      check("seq busy", 8'(seen[2]), 8'h00);
      nv_busy <= 1'b0;
      repeat (4) @(posedge mclk);
      check("seq late", 8'(seen[2]), 8'h01);
      quad_active <= 1'b0;
      $display("test sequence done");
   endtask

   // -----------------------------------------------------------
   // Main sequence and watchdog
   // -----------------------------------------------------------
   initial begin
      repeat (8) @(posedge mclk);
      arst_n <= 1'b1;
      repeat (2) @(posedge mclk);
      t_otp();
      t_wake();
      t_hold();
      t_pin_reset();
      t_seq();
      end_of_test();
   end
   initial begin
      #2_000_000;
      n_mismatch++;
      end_of_test();
   end
endmodule
`default_nettype wire
